/* hdl/tef_pkg.sv */
// Constants, register map and carrier types for the ESF framer.
// Assumes a 100 MHz hclk and a bit-serial T1 line sampled on strobes.
package tef_pkg;

  // ==========================================================
  // Frame structure
  localparam int          MF_FRAMES = 24;
  localparam int          FAS_BITS  = 6;
  localparam int          FAS_STEP  = 4;
  localparam int          FAS_FIRST = 3;
  localparam logic [7:0]  POS_LAST  = 8'hC0;
  localparam logic [4:0]  FRM_LAST  = 5'h17;
  localparam logic [5:0]  FRM_COUNT = 6'h18;
  localparam logic [5:0]  FAS_PAT   = 6'h34;
  localparam logic [5:0]  CRC_POLY  = 6'h03;
  localparam logic [2:0]  CRC_MSB   = 3'h5;
  localparam logic [1:0]  SLOT_CRC  = 2'h1;
  localparam logic [1:0]  SLOT_FAS  = 2'h3;

  // ==========================================================
  // Alarm and loss figures
  localparam logic [15:0] RAI_PAT      = 16'hFF00;
  localparam logic [15:0] JRAI_PAT     = 16'hFFFF;
  localparam logic [4:0]  RAI_HOLD     = 5'h10;
  localparam logic [4:0]  RAI_TOL      = 5'h01;
  localparam logic [8:0]  CRC_LOSS_LIM = 9'h140;
  localparam logic [1:0]  CONF_NEED    = 2'h3;
  localparam logic [1:0]  BAD_RUN      = 2'h3;
  localparam int          CLK_MHZ      = 100;
  localparam int          CRC_WIN_S    = 1;
  localparam int          CRC_WIN_CYC  = CRC_WIN_S * CLK_MHZ * 1000000;

  // ==========================================================
  // Register map
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_STAT  = 12'h004;
  localparam logic [11:0] OFS_CNT   = 12'h008;
  localparam logic [2:0]  SZ_WORD   = 3'h2;
  localparam int          CTRL_FRS  = 0;
  localparam int          CTRL_EXL  = 1;
  localparam int          CTRL_LSB  = 2;
  localparam int          CTRL_MSB  = 13;
  localparam int          STAT_CRCE = 3;
  localparam logic [1:0]  SSC_RUN   = 2'h3;
  localparam logic [1:0]  MODE_SINGLE = 2'h0;
  localparam logic [1:0]  MODE_CONF3  = 2'h1;
  localparam logic [1:0]  MODE_STEP   = 2'h2;
  localparam logic [1:0]  MODE_CRC    = 2'h3;

  typedef struct packed {
    logic       mf_err_loss_en;
    logic       tx_crc_invert;
    logic       auto_crc_invert;
    logic       crc_check_enable;
    logic       transmit_remote_alarm;
    logic       remote_alarm_select;
    logic       japan_mode;
    logic       separate_sync_proc;
    logic       multi_candidate_mode;
    logic       crc_loss_enable;
    logic [1:0] sync_condition_sel;
  } tef_ctrl_t;

  typedef struct packed {
    logic confirming;
    logic crc_err;
    logic remote_alarm;
    logic search_restart_flag;
    logic frame_loss_flag;
  } tef_stat_t;

  typedef enum logic [1:0] {ST_HUNT, ST_CONFIRM, ST_SYNC} tef_state_t;

endpackage

/* hdl/tef_framer.sv */
// ESF receive synchroniser, CRC6 check/generate and remote alarm.
// Assumes line bits and strobes arrive from another domain, AHB-Lite host.
//
// Function
// - 24 frames; F-bit carries DL, CRC, alignment
// - Sync on definite candidate or forced lock
// - Lose sync on 2 errors in 4/5/6
// - Optional loss on 2 errors per multiframe
// - Optional loss above 320 CRC errors/second
// - Loss after 4 consecutive bad multiframes
// - Mode 00 sync commands restart search
// - Mode 00 async force locks, clears memory
// - Mode 01 needs 3 correct multiframes
// - Mode 10 force steps to next candidate
// - Mode 10 no candidate: restart, toggle flag
// - Mode 11 needs pattern plus good CRC6
// - Detect alarm pattern 1111 1111 0000 0000
// - Alarm detection tolerates 1e-3 errors
// - Japanese alarm: sixteen ones sent
// - CRC6 checked/generated; disabled sends ones
// - Sync CRC errors counted and flagged
// - Auto invert after received CRC error
// - Manual invert ORed with auto invert
// - Japanese CRC includes F/DL bits
// - Sync condition field selects loss rule
// - Loss flag and framing error counter
// - Restart flag toggles on empty search
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module tef_framer #(
  parameter int CRC_WIN_CYCLES = tef_pkg::CRC_WIN_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_line_bit,
  input  wire logic        rx_bit_strobe,
  input  wire logic        tx_payload_bit,
  input  wire logic        tx_bit_strobe,
  output logic             tx_line_bit
);

  if (CRC_WIN_CYCLES < 2) begin : g_chk
    $error("CRC_WIN_CYCLES too small");
  end

  // ==========================================================
  // Helpers
  function automatic logic [4:0] mod24(input logic [5:0] x);
    return (x >= tef_pkg::FRM_COUNT) ? 5'(x - tef_pkg::FRM_COUNT) : x[4:0];
  endfunction

  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic b);
    return {c[4:0], 1'b0} ^ ((c[5] ^ b) ? tef_pkg::CRC_POLY : 6'h00);
  endfunction

  function automatic logic [4:0] ones16(input logic [15:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) n = n + 5'(v[i]);
    return n;
  endfunction

  // Search a 24-frame history for the alignment word at any phase
  function automatic logic [5:0] fas_find(input logic [23:0] h);
    logic [5:0] r;
    logic       ok;
    int         k;
    r = '0;
    for (int f = 0; f < tef_pkg::MF_FRAMES; f++) begin
      ok = 1'b1;
      for (int i = 0; i < tef_pkg::FAS_BITS; i++) begin
        k = (f + tef_pkg::MF_FRAMES - tef_pkg::FAS_FIRST
             - tef_pkg::FAS_STEP * i) % tef_pkg::MF_FRAMES;
        if (h[k] != tef_pkg::FAS_PAT[i]) ok = 1'b0;
      end
      if (ok && !r[5]) r = {1'b1, 5'(f)};
    end
    return r;
  endfunction

  // Up to one bit error per 16 keeps a 1e-3 line declared
  function automatic logic rai_ok(input logic [15:0] w, input logic jp);
    logic        ok;
    logic [31:0] pp;
    ok = ones16(w ^ tef_pkg::JRAI_PAT) <= tef_pkg::RAI_TOL;
    if (!jp) begin
      ok = 1'b0;
      for (int r = 0; r < 16; r++) begin
        pp = {tef_pkg::RAI_PAT, tef_pkg::RAI_PAT} >> r;
        if (ones16(w ^ pp[15:0]) <= tef_pkg::RAI_TOL) ok = 1'b1;
      end
    end
    return ok;
  endfunction

  // ==========================================================
  // AHB-Lite slave, zero wait states
  tef_pkg::tef_ctrl_t ctrl_q;
  tef_pkg::tef_stat_t stat;
  logic [11:0] ra;
  logic        acc;
  logic        wr_q;
  logic [11:0] wa_q;
  logic [31:0] rd_d;
  logic [31:0] hrdata_q;
  logic [15:0] fec_q;
  logic [15:0] crcc_q;
  wire         wr_ctrl = wr_q & (wa_q == tef_pkg::OFS_CTRL);
  wire         wr_stat = wr_q & (wa_q == tef_pkg::OFS_STAT);
  wire         frs = wr_ctrl & hwdata[tef_pkg::CTRL_FRS];
  wire         exl = wr_ctrl & hwdata[tef_pkg::CTRL_EXL];

  assign ra  = haddr[11:0];
  assign acc = hsel & htrans[1] & hready & (hsize == tef_pkg::SZ_WORD);
  assign rd_d = (ra == tef_pkg::OFS_CTRL) ?
                  32'(ctrl_q) << tef_pkg::CTRL_LSB :
                (ra == tef_pkg::OFS_STAT) ? 32'(stat) :
                (ra == tef_pkg::OFS_CNT)  ? {crcc_q, fec_q} : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      wa_q     <= '0;
      hrdata_q <= '0;
      ctrl_q   <= '0;
    end else begin
      wr_q <= acc & hwrite;
      wa_q <= ra;
      if (acc && !hwrite) hrdata_q <= rd_d;
      if (wr_ctrl)
        ctrl_q <= hwdata[tef_pkg::CTRL_MSB:tef_pkg::CTRL_LSB];
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [1:0] s3_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {tx_payload_bit, tx_bit_strobe, rx_line_bit, rx_bit_strobe};
      s2_q <= s1_q;
      s3_q <= {s2_q[2], s2_q[0]};
    end
  end
  wire rx_tick = s2_q[0] & ~s3_q[0];
  wire rxb     = s2_q[1];
  wire tx_tick = s2_q[2] & ~s3_q[1];
  wire txp     = s2_q[3];

  // ==========================================================
  // Receive framing decode
  tef_pkg::tef_state_t st_q;
  logic [7:0]  rx_pos_q;
  logic [4:0]  rx_frm_q;
  logic [23:0] hist_q [0:192];
  logic [192:0] disc_q;
  logic [7:0]  lk_pos_q;
  logic [4:0]  lk_off_q;
  wire [1:0] mode   = {ctrl_q.multi_candidate_mode, ctrl_q.separate_sync_proc};
  wire hunt   = (st_q == tef_pkg::ST_HUNT);
  wire conf   = (st_q == tef_pkg::ST_CONFIRM);
  wire insync = (st_q == tef_pkg::ST_SYNC);
  wire [23:0] h_new = {hist_q[rx_pos_q][22:0], rxb};
  wire [5:0]  fm    = fas_find(h_new);
  wire        fhit  = rx_tick & fm[5] & ~disc_q[rx_pos_q];
  wire [4:0]  hoff  = mod24(6'(fm[4:0]) + tef_pkg::FRM_COUNT
                            - {1'b0, rx_frm_q});
  wire pass_end = rx_tick & (rx_pos_q == tef_pkg::POS_LAST);
  wire fb  = rx_tick & ~hunt & (rx_pos_q == lk_pos_q);
  wire [4:0] fi = mod24({1'b0, rx_frm_q} + {1'b0, lk_off_q});
  wire al_bit = fb & (fi[1:0] == tef_pkg::SLOT_FAS);
  wire al_err = al_bit & (rxb != tef_pkg::FAS_PAT[fi[4:2]]);
  wire e_bit  = fb & (fi[1:0] == tef_pkg::SLOT_CRC);
  wire dl_bit = fb & ~fi[0];
  wire mf_start = fb & (fi == 5'h00);
  wire mf_end   = al_bit & (fi == tef_pkg::FRM_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pos_q <= '0;
      rx_frm_q <= '0;
      for (int i = 0; i <= 192; i++) hist_q[i] <= '0;
    end else if (rx_tick) begin
      hist_q[rx_pos_q] <= h_new;
      rx_pos_q <= pass_end ? 8'h00 : rx_pos_q + 8'h01;
      if (pass_end)
        rx_frm_q <= (rx_frm_q == tef_pkg::FRM_LAST) ? 5'h00 : rx_frm_q + 5'h01;
    end
  end

  // ==========================================================
  // Candidate memory per search pass (one frame of positions)
  logic [1:0] pc_q;
  logic [1:0] lc_q;
  logic [7:0] pp_q;
  logic [7:0] lp_q;
  logic [4:0] po_q;
  logic [4:0] lo_q;
  logic       want_q;
  wire  [1:0] pc_n  = (fhit && pc_q != 2'h2) ? pc_q + 2'h1 : pc_q;
  wire  [7:0] fpos  = (pc_q == 2'h0) ? rx_pos_q : pp_q;
  wire  [4:0] foff  = (pc_q == 2'h0) ? hoff : po_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= '0; lc_q <= '0; pp_q <= '0;
      lp_q <= '0; po_q <= '0; lo_q <= '0;
    end else if (pass_end) begin
      pc_q <= '0; lc_q <= pc_n; lp_q <= fpos; lo_q <= foff;
    end else if (fhit) begin
      pc_q <= pc_n;
      if (pc_q == 2'h0) begin
        pp_q <= rx_pos_q;
        po_q <= hoff;
      end
    end
  end

  // ==========================================================
  // Synchroniser decisions
  logic       crc_mis;
  logic       crc_eval;
  logic       loss_any;
  logic [1:0] conf_q;
  wire cmd_frs  = frs & ~exl;
  wire lock_frs = hunt & cmd_frs & (lc_q != 2'h0);
  wire lock_want = hunt & ~frs & ~exl & want_q & fhit;
  // Without separate_sync_proc, two or more candidates in a pass are treated as imitations
  wire lock_pass = hunt & ~frs & ~exl & pass_end &
                   ((pc_n == 2'h1) |
                    (ctrl_q.separate_sync_proc & pc_n != 2'h0));
  wire restart = hunt & ~exl & ((cmd_frs & lc_q == 2'h0) |
                 (~frs & ~lock_want & pass_end & pc_n == 2'h0));
  wire lock = lock_frs | lock_want | lock_pass;
  wire [7:0] lock_pos = lock_frs ? lp_q : lock_want ? rx_pos_q : fpos;
  wire [4:0] lock_off = lock_frs ? lo_q : lock_want ? hoff : foff;
  wire conf_fail = conf & (al_err | (mode == tef_pkg::MODE_CRC &
                                     crc_eval & crc_mis));
  wire conf_pass = conf & ~al_err & (
                   (mode == tef_pkg::MODE_CONF3 & mf_end &
                    conf_q == tef_pkg::CONF_NEED - 2'h1) |
                   (mode == tef_pkg::MODE_CRC & crc_eval & ~crc_mis));
  wire step_frs = ~hunt & cmd_frs & (mode == tef_pkg::MODE_STEP);
  logic srf_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= tef_pkg::ST_HUNT;
      disc_q <= '0; want_q <= 1'b0; srf_q <= 1'b0;
      lk_pos_q <= '0; lk_off_q <= '0; conf_q <= '0;
    end else begin
      if (exl || (~hunt && cmd_frs && !step_frs) || restart ||
          (insync && loss_any) || (lock_frs && mode == tef_pkg::MODE_SINGLE))
        disc_q <= '0;
      else if (step_frs || conf_fail)
        disc_q[lk_pos_q] <= 1'b1;
      if (restart) srf_q <= ~srf_q;
      want_q <= step_frs | (want_q & hunt & ~lock & ~restart & ~exl);
      if (conf_pass) conf_q <= '0;
      else if (conf & mf_end) conf_q <= conf_q + 2'h1;
      if (exl || (~hunt && frs) || conf_fail || (insync && loss_any))
        st_q <= tef_pkg::ST_HUNT;
      else if (lock) begin
        st_q <= ctrl_q.separate_sync_proc ? tef_pkg::ST_CONFIRM
                                          : tef_pkg::ST_SYNC;
        lk_pos_q <= lock_pos;
        lk_off_q <= lock_off;
        conf_q <= 2'h1;
      end else if (conf_pass)
        st_q <= tef_pkg::ST_SYNC;
    end
  end

  // ==========================================================
  // Loss detection in sync
  logic [5:0] eh_q;
  logic [1:0] mfe_q;
  logic [1:0] run_q;
  logic [8:0] csec_q;
  logic [31:0] sec_q;
  wire [5:0] wn   = {eh_q[4:0], al_err};
  wire [5:0] wmsk = (ctrl_q.sync_condition_sel == 2'h0) ? 6'h0F :
                    (ctrl_q.sync_condition_sel == 2'h1) ? 6'h1F : 6'h3F;
  wire [4:0] mtot = 5'(mfe_q) + 5'(al_err);
  wire loss_win = al_bit & (ctrl_q.sync_condition_sel != tef_pkg::SSC_RUN)
                  & (ones16({10'h000, wn & wmsk}) >= 5'h02);
  wire loss_mf  = mf_end & ctrl_q.mf_err_loss_en & (mtot >= 5'h02);
  wire loss_run = mf_end & (ctrl_q.sync_condition_sel == tef_pkg::SSC_RUN)
                  & (mtot != 5'h00) & (run_q == tef_pkg::BAD_RUN);
  wire loss_crc = ctrl_q.crc_loss_enable &
                  (csec_q > tef_pkg::CRC_LOSS_LIM);
  wire sec_end  = (sec_q == 32'(CRC_WIN_CYCLES - 1));
  assign loss_any = loss_win | loss_mf | loss_run | loss_crc;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eh_q <= '0; mfe_q <= '0; run_q <= '0;
    end else if (lock) begin
      eh_q <= '0; mfe_q <= '0; run_q <= '0;
    end else if (al_bit) begin
      eh_q  <= wn;
      mfe_q <= mf_end ? 2'h0 : (mtot >= 5'h02) ? 2'h2 : mtot[1:0];
      if (mf_end)
        run_q <= (mtot == 5'h00) ? 2'h0 :
                 (run_q == tef_pkg::BAD_RUN) ? run_q : run_q + 2'h1;
    end
  end

  // ==========================================================
  // Received CRC6 check
  logic [5:0] crc_q;
  logic [5:0] cprev_q;
  logic [5:0] e_q;
  logic [1:0] seen_q;
  logic       rxbad_q;
  logic       crce_q;
  wire crc_in = (fb & ~ctrl_q.japan_mode) | rxb;
  wire crc_err = crc_eval & crc_mis & ctrl_q.crc_check_enable & insync;
  assign crc_eval = mf_start & (seen_q == 2'h2);
  assign crc_mis  = (e_q != cprev_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= '0; cprev_q <= '0; e_q <= '0; seen_q <= '0; rxbad_q <= 1'b0;
    end else begin
      if (lock) seen_q <= '0;
      else if (mf_start && seen_q != 2'h2) seen_q <= seen_q + 2'h1;
      if (mf_start) begin
        cprev_q <= crc_q;
        crc_q   <= crc_step(6'h00, crc_in);
      end else if (rx_tick) crc_q <= crc_step(crc_q, crc_in);
      if (e_bit) e_q[tef_pkg::CRC_MSB - fi[4:2]] <= rxb;
      if (crc_eval)
        rxbad_q <= crc_mis & ctrl_q.crc_check_enable;
    end
  end

  // ==========================================================
  // Counters, status, one-second CRC window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fec_q <= '0; crcc_q <= '0; crce_q <= 1'b0;
      sec_q <= '0; csec_q <= '0;
    end else begin
      if (insync && al_err) fec_q <= fec_q + 16'h0001;
      if (crc_err) crcc_q <= crcc_q + 16'h0001;
      // Set wins over a clear in the same cycle
      crce_q <= crc_err | (crce_q & ~(wr_stat & hwdata[tef_pkg::STAT_CRCE]));
      sec_q  <= sec_end ? 32'h0 : sec_q + 32'h1;
      if (sec_end || !insync) csec_q <= '0;
      else if (crc_err && csec_q != 9'h1FF) csec_q <= csec_q + 9'h001;
    end
  end

  // ==========================================================
  // Remote alarm detection
  logic [15:0] dl_q;
  logic [4:0]  rc_q;
  logic        rai_q;
  wire [15:0] dl_n  = {dl_q[14:0], rxb};
  wire        dl_ok = rai_ok(dl_n, ctrl_q.japan_mode);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_q <= '0; rc_q <= '0; rai_q <= 1'b0;
    end else if (dl_bit) begin
      dl_q <= dl_n;
      if (dl_ok == rai_q) rc_q <= '0;
      else if (rc_q == tef_pkg::RAI_HOLD - 5'h01) begin
        rc_q  <= '0;
        rai_q <= dl_ok;
      end else rc_q <= rc_q + 5'h01;
    end
  end

  assign stat = '{confirming: conf, crc_err: crce_q, remote_alarm: rai_q,
                  search_restart_flag: srf_q, frame_loss_flag: ~insync};

  // ==========================================================
  // Transmit framing and CRC6 generation
  logic [7:0] tx_pos_q;
  logic [4:0] tx_frm_q;
  logic [5:0] tcrc_q;
  logic [5:0] tprev_q;
  logic       tinv_q;
  logic [3:0] tdl_q;
  logic       tx_q;
  logic       tx_dl;
  wire tx_f   = (tx_pos_q == 8'h00);
  wire tx_mfs = tx_f & (tx_frm_q == 5'h00);
  wire tinv_n = ctrl_q.tx_crc_invert |
                (ctrl_q.auto_crc_invert & rxbad_q);
  wire tx_e   = ctrl_q.crc_check_enable ?
                tprev_q[tef_pkg::CRC_MSB - tx_frm_q[4:2]] ^ tinv_q : 1'b1;
  assign tx_dl = ~ctrl_q.transmit_remote_alarm ? 1'b1 :
                 (ctrl_q.japan_mode & ~ctrl_q.remote_alarm_select) ?
                 tef_pkg::JRAI_PAT[tdl_q] :
                 tef_pkg::RAI_PAT[4'hF - tdl_q];
  wire tx_fb  = ~tx_frm_q[0] ? tx_dl :
                (tx_frm_q[1:0] == tef_pkg::SLOT_CRC) ? tx_e :
                tef_pkg::FAS_PAT[tx_frm_q[4:2]];
  wire tx_b   = tx_f ? tx_fb : txp;
  wire tcin   = (tx_f & ~ctrl_q.japan_mode) | tx_b;
  assign tx_line_bit = tx_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pos_q <= '0; tx_frm_q <= '0; tcrc_q <= '0;
      tprev_q <= '0; tinv_q <= 1'b0; tdl_q <= '0; tx_q <= 1'b1;
    end else if (tx_tick) begin
      tx_q <= tx_b;
      tx_pos_q <= (tx_pos_q == tef_pkg::POS_LAST) ? 8'h00 : tx_pos_q + 8'h01;
      if (tx_pos_q == tef_pkg::POS_LAST)
        tx_frm_q <= (tx_frm_q == tef_pkg::FRM_LAST) ? 5'h00 : tx_frm_q + 5'h01;
      if (tx_f && !tx_frm_q[0]) tdl_q <= tdl_q + 4'h1;
      if (tx_mfs) begin
        tprev_q <= tcrc_q;
        tinv_q  <= tinv_n;
        tcrc_q  <= crc_step(6'h00, tcin);
      end else tcrc_q <= crc_step(tcrc_q, tcin);
    end
  end

endmodule
`default_nettype wire

/* sim/tef_framer_monitor.sv */
// Checker for the framer's bus and transmit ports.
// Assumes it is bound onto tef_framer; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module tef_framer_monitor #(
  parameter int CRC_WIN_CYCLES = 100
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        tx_bit_strobe,
  input wire logic        tx_line_bit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire        rd = hsel & htrans[1] & hready & !hwrite
                   & (hsize == tef_pkg::SZ_WORD);
  wire [11:0] a  = haddr[11:0];
  // ==========================================================
  // Properties
  property p_rdy; hreadyout == 1'b1; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_ctrl;
    rd && a == tef_pkg::OFS_CTRL |=> hrdata[1:0] == 2'h0
      && hrdata[31:14] == 18'h0;
  endproperty
  property p_stat;
    rd && a == tef_pkg::OFS_STAT |=> hrdata[31:5] == 27'h0;
  endproperty
  property p_unmap; rd && a >= 12'h00C |=> hrdata == 32'h0; endproperty
  property p_hold; $changed(hrdata) |-> $past(rd); endproperty
  // Shared strobe pins sit three cycles ahead of the line bit
  property p_txchg;
    $changed(tx_line_bit) |-> $past(tx_bit_strobe, 3);
  endproperty
  property p_txrst; $rose(hresetn) |-> tx_line_bit; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_ctrl: assert property (p_ctrl) else $error("ctrl read bad");
  a_stat: assert property (p_stat) else $error("stat read bad");
  a_unmap: assert property (p_unmap) else $error("unmapped not 0");
  a_hold: assert property (p_hold) else $error("hrdata moved");
  a_txchg: assert property (p_txchg) else $error("tx off strobe");
  a_txrst: assert property (p_txrst) else $error("tx idle not 1");
  c_stat: cover property (rd && a == tef_pkg::OFS_STAT);
  c_cnt: cover property (rd && a == tef_pkg::OFS_CNT);
  c_tx: cover property ($changed(tx_line_bit));
endmodule
bind tef_framer tef_framer_monitor #(.CRC_WIN_CYCLES(CRC_WIN_CYCLES)) mon (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hreadyout, .hrdata, .hresp, .tx_bit_strobe, .tx_line_bit);
`default_nettype wire

/* sim/tef_far_end.sv */
// Far terminal: sends an ESF line stream and checks the sent F-bits.
// Assumes one bit strobe for both directions, crc and alarm send off.
`timescale 1ns/1ns
`default_nettype none
module tef_far_end (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       alarm_on,
  input  wire logic       bad_fas,
  input  wire logic       tx_line_bit,
  output logic            strobe,
  output logic            line_bit,
  output logic [7:0]      tx_err
);
  logic [1:0] ph_q;
  logic [7:0] bit_q;
  logic [4:0] frm_q;
  logic [3:0] dl_q;
  wire        pat = tef_pkg::FAS_PAT[frm_q[4:2]];
  wire        exp_f = !frm_q[0] | !frm_q[1] | pat;
  // Payload zeros so no imitation candidate exists
  assign strobe = ph_q[1];
  assign line_bit = (bit_q != 8'h0) ? 1'b0 :
                    !frm_q[0] ? (!alarm_on | !dl_q[3]) :
                    frm_q[1] ? pat ^ bad_fas : 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 2'h0;
      bit_q <= 8'h0;
      frm_q <= 5'h0;
      dl_q <= 4'h0;
      tx_err <= 8'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h2 && bit_q == 8'h1 && tx_line_bit !== exp_f)
        tx_err <= tx_err + 8'h1;
      if (ph_q == 2'h3) begin
        bit_q <= (bit_q == 8'hC0) ? 8'h0 : bit_q + 8'h1;
        if (bit_q == 8'hC0)
          frm_q <= (frm_q == 5'h17) ? 5'h0 : frm_q + 5'h1;
        if (bit_q == 8'hC0 && !frm_q[0])
          dl_q <= dl_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/t1_esf_framer_sync_crc6_bench.sv */
// Testbench: registers, sync, alarm, resync and loss of the framer.
// Assumes tef_far_end on the line and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module t1_esf_framer_sync_crc6_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = tef_pkg::SZ_WORD;
  logic [31:0] hwdata = 32'h0;
  logic        alarm_on = 1'b0;
  logic        bad_fas = 1'b0;
  logic        tx_pay = 1'b0;
  wire         hready;
  wire  [31:0] hrdata;
  wire         hresp;
  wire         strobe;
  wire         line_bit;
  wire         tx_line_bit;
  wire  [7:0]  tx_err;
  logic [31:0] r;
  logic [31:0] s;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #5 hclk = ~hclk;
  tef_framer #(.CRC_WIN_CYCLES(2000)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .rx_line_bit(line_bit),
    .rx_bit_strobe(strobe), .tx_payload_bit(tx_pay),
    .tx_bit_strobe(strobe), .tx_line_bit(tx_line_bit));
  tef_far_end far (.hclk(hclk), .hresetn(hresetn), .alarm_on(alarm_on),
    .bad_fas(bad_fas), .tx_line_bit(tx_line_bit), .strobe(strobe),
    .line_bit(line_bit), .tx_err(tx_err));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Bounded status poll; the caller compares the last read
  task automatic poll(input logic [31:0] m, input logic [31:0] e,
                      input int n);
    for (int i = 0; i < n; i++) begin
      xfer(1'b0, tef_pkg::OFS_STAT, 32'h0);
      if ((r & m) === e)
        break;
      repeat (40) @(posedge hclk);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    // Sync, alarm hold and loss take about 80000 cycles at worst
    #950000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, tef_pkg::OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, tef_pkg::OFS_STAT, 32'h0);
    s = r;
    chk(r & 32'hFFFF_FFFD, 32'h1);
    xfer(1'b0, tef_pkg::OFS_CNT, 32'h0);
    chk(r, 32'h0);
    xfer(1'b1, tef_pkg::OFS_CTRL, 32'h3FFF);
    xfer(1'b0, tef_pkg::OFS_CTRL, 32'h0);
    chk(r, 32'h3FFC);
    // Forced resync with no candidate yet must restart and toggle
    xfer(1'b1, tef_pkg::OFS_CTRL, 32'h1);
    xfer(1'b0, tef_pkg::OFS_STAT, 32'h0);
    chk({31'h0, r[1]}, {31'h0, ~s[1]});
    xfer(1'b1, 12'h00C, 32'hFFFF_FFFF);
    xfer(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, tef_pkg::OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    alarm_on <= 1'b1;
    poll(32'h1, 32'h0, 900);
    chk(r & 32'h11, 32'h0);
    chk({24'h0, tx_err}, 32'h0);
    // Up to 32 data-link bits, two frames apart, before the alarm shows
    poll(32'h4, 32'h4, 1300);
    chk(r & 32'h4, 32'h4);
    xfer(1'b1, tef_pkg::OFS_CTRL, 32'h2);
    xfer(1'b0, tef_pkg::OFS_STAT, 32'h0);
    chk(r & 32'h1, 32'h1);
    poll(32'h1, 32'h0, 900);
    chk(r & 32'h1, 32'h0);
    xfer(1'b0, tef_pkg::OFS_CNT, 32'h0);
    chk(r, 32'h0);
    bad_fas <= 1'b1;
    poll(32'h1, 32'h1, 300);
    chk(r & 32'h1, 32'h1);
    xfer(1'b0, tef_pkg::OFS_CNT, 32'h0);
    chk({31'h0, r[15:0] >= 16'h2}, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
